// File: verilog/sotp_slave.sv
// serial command slave of a 64k x 8 one-time-programmable rom
// assumes the array answers i_mem_rdata combinationally to o_mem_req.addr
// and that half an sck period spans at least ten i_clk cycles
`timescale 1ns/100ps
`default_nettype none

module sotp_slave #(
   parameter logic [7:0] MAKER_CODE = 8'h5a,  // arbitrary value
   parameter logic [7:0] DEVICE_CODE = 8'ha5  // arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_hold_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_mode3,
   output sotp_pkg::sotp_mem_req_t o_mem_req,
   input wire logic [7:0] i_mem_rdata
);

   sotp_pkg::sotp_rise_t rise_ff;
   sotp_pkg::sotp_rise_t nxt_rise;
   sotp_pkg::sotp_fall_t fall_ff;
   sotp_pkg::sotp_fall_t nxt_fall;
   sotp_pkg::sotp_sys_t sys_ff;
   sotp_pkg::sotp_sys_t nxt_sys;
   logic [7:0] opc;
   logic [7:0] out_src;
   logic out_phase;
   logic cs_fall;
   logic sel_live;

   function automatic logic op_hit(input logic [7:0] v, input logic [7:0] pat,
                                   input logic [7:0] mask);
      op_hit = ((v ^ pat) & mask) == 8'h00;
   endfunction

   // stages two and three agree: the pin has settled
   function automatic logic pin_settled(input logic [3:0] a, input logic [3:0] b,
                                        input int idx);
      pin_settled = a[idx] == b[idx];
   endfunction

   // stages two and three differ: the sck side has flipped a toggle
   function automatic logic pin_toggled(input logic [3:0] a, input logic [3:0] b,
                                        input int idx);
      pin_toggled = a[idx] != b[idx];
   endfunction

   assign opc = {rise_ff.sh[6:0], i_si};

   // rising sck: command, address and data capture
   always_comb begin
      nxt_rise = rise_ff;
      if (i_hold_n) begin
         nxt_rise.bitcnt = rise_ff.bitcnt + 5'h01;
         case (rise_ff.cmd)
            sotp_pkg::ST_OPC: begin
               nxt_rise.sh = opc;
               if (rise_ff.bitcnt == sotp_pkg::OPC_LAST) begin
                  if (op_hit(opc, sotp_pkg::OP_READ, sotp_pkg::OP_MASK_X)) begin
                     nxt_rise.cmd = sotp_pkg::ST_RPAD;
                  end else if (op_hit(opc, sotp_pkg::OP_STAT, sotp_pkg::OP_MASK_X)) begin
                     nxt_rise.cmd = sotp_pkg::ST_STAT;
                     nxt_rise.bitcnt = 5'h00;
                  end else if (op_hit(opc, sotp_pkg::OP_IDENT, sotp_pkg::OP_MASK_X)) begin
                     nxt_rise.cmd = sotp_pkg::ST_IDENT;
                     nxt_rise.bitcnt = 5'h00;
                     nxt_rise.ident_dev = 1'b0;
                  end else if (op_hit(opc, sotp_pkg::OP_PROG, sotp_pkg::OP_MASK_ALL)) begin
                     nxt_rise.cmd = sotp_pkg::ST_PADDR;
                  end else begin
                     nxt_rise.cmd = sotp_pkg::ST_IGN;
                  end
               end
            end
            sotp_pkg::ST_RPAD: begin
               // a set last pad bit is not a valid read frame
               if (rise_ff.bitcnt == sotp_pkg::PAD_LAST) begin
                  nxt_rise.cmd = i_si ? sotp_pkg::ST_IGN : sotp_pkg::ST_RADDR;
               end
            end
            sotp_pkg::ST_RADDR: begin
               nxt_rise.addr = {rise_ff.addr[14:0], i_si};
               if (rise_ff.bitcnt == sotp_pkg::ADDR_LAST) begin
                  nxt_rise.cmd = sotp_pkg::ST_RDATA;
                  nxt_rise.bitcnt = 5'h00;
                  nxt_rise.rd_addr = {rise_ff.addr[14:0], i_si};
                  nxt_rise.rd_tog = ~rise_ff.rd_tog;
               end
            end
            sotp_pkg::ST_RDATA: begin
               // prefetch the next byte right after the current one is loaded;
               // serial input is not looked at here
               if (rise_ff.bitcnt[2:0] == sotp_pkg::BYTE_FIRST) begin
                  nxt_rise.rd_addr = rise_ff.rd_addr + 16'h0001;
                  nxt_rise.rd_tog = ~rise_ff.rd_tog;
               end
            end
            sotp_pkg::ST_STAT: begin
               nxt_rise.ident_dev = 1'b0;
            end
            sotp_pkg::ST_IDENT: begin
               if (rise_ff.bitcnt[2:0] == sotp_pkg::BYTE_LAST) begin
                  nxt_rise.ident_dev = ~rise_ff.ident_dev;
               end
            end
            sotp_pkg::ST_PADDR: begin
               // only the low 16 of the 24 address bits reach the array
               nxt_rise.addr = {rise_ff.addr[14:0], i_si};
               if (rise_ff.bitcnt == sotp_pkg::ADDR_LAST) begin
                  nxt_rise.cmd = sotp_pkg::ST_PDATA;
                  nxt_rise.bitcnt = 5'h00;
               end
            end
            sotp_pkg::ST_PDATA: begin
               nxt_rise.sh = opc;
               if (rise_ff.bitcnt[2:0] == sotp_pkg::BYTE_LAST) begin
                  nxt_rise.wr_data = opc;
                  nxt_rise.wr_addr = rise_ff.addr;
                  nxt_rise.wr_tog = ~rise_ff.wr_tog;
                  nxt_rise.addr = rise_ff.addr + 16'h0001;
               end
            end
            sotp_pkg::ST_IGN: begin
               nxt_rise.bitcnt = rise_ff.bitcnt;
            end
            default: begin
               nxt_rise.cmd = sotp_pkg::ST_IGN;
            end
         endcase
      end
   end

   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         rise_ff <= sotp_pkg::RISE_RST;
      end else begin
         rise_ff <= nxt_rise;
      end
   end

   // falling sck: output shifter
   always_comb begin
      out_phase = 1'b0;
      out_src = sotp_pkg::STATUS_BYTE;
      case (rise_ff.cmd)
         sotp_pkg::ST_RDATA: begin
            out_phase = 1'b1;
            out_src = sys_ff.rdata;
         end
         sotp_pkg::ST_STAT: begin
            out_phase = 1'b1;
         end
         sotp_pkg::ST_IDENT: begin
            out_phase = 1'b1;
            out_src = rise_ff.ident_dev ? DEVICE_CODE : MAKER_CODE;
         end
         default: begin
            out_phase = 1'b0;
         end
      endcase
   end

   always_comb begin
      nxt_fall = fall_ff;
      if (i_hold_n && out_phase) begin
         nxt_fall.oe = 1'b1;
         if (rise_ff.bitcnt[2:0] == sotp_pkg::BYTE_FIRST) begin
            nxt_fall.byte_q = out_src;
            nxt_fall.so = out_src[7];
         end else begin
            nxt_fall.so = fall_ff.byte_q[sotp_pkg::BYTE_LAST - rise_ff.bitcnt[2:0]];
         end
      end
   end

   always_ff @(negedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         fall_ff <= sotp_pkg::FALL_RST;
      end else begin
         fall_ff <= nxt_fall;
      end
   end

   // system clock: select watch, mode detect, array port
   assign cs_fall = sys_ff.cs_f && pin_settled(sys_ff.s2, sys_ff.s3, sotp_pkg::SY_CS)
                    && !sys_ff.s2[sotp_pkg::SY_CS];

   // a raised select clears the sck-side toggles; select travels in the same
   // stages, so a toggle seen with select high is that clear, not a request
   assign sel_live = !sys_ff.s2[sotp_pkg::SY_CS];

   always_comb begin
      nxt_sys = sys_ff;
      nxt_sys.s1 = {rise_ff.wr_tog, rise_ff.rd_tog, i_sck, i_cs_n};
      nxt_sys.s2 = sys_ff.s1;
      nxt_sys.s3 = sys_ff.s2;
      nxt_sys.mem.we = 1'b0;
      // pins count only once stages two and three agree
      if (pin_settled(sys_ff.s2, sys_ff.s3, sotp_pkg::SY_CS)) begin
         nxt_sys.cs_f = sys_ff.s2[sotp_pkg::SY_CS];
      end
      if (pin_settled(sys_ff.s2, sys_ff.s3, sotp_pkg::SY_SCK)) begin
         nxt_sys.sck_f = sys_ff.s2[sotp_pkg::SY_SCK];
      end
      if (sys_ff.cs_f) begin
         nxt_sys.seen_high = 1'b1;
      end
      if (cs_fall) begin
         nxt_sys.mode3 = sys_ff.sck_f;
         nxt_sys.armed = sys_ff.seen_high;
      end
      if (sys_ff.rd_pend) begin
         nxt_sys.rdata = i_mem_rdata;
         nxt_sys.rd_pend = 1'b0;
      end
      // sck-side address words are stable for at least one sck period after a toggle
      if (pin_toggled(sys_ff.s2, sys_ff.s3, sotp_pkg::SY_RD) && sel_live) begin
         nxt_sys.mem.addr = rise_ff.rd_addr;
         nxt_sys.rd_pend = 1'b1;
      end
      // without the select gate the clear would write zero to address zero
      if (pin_toggled(sys_ff.s2, sys_ff.s3, sotp_pkg::SY_WR) && sel_live) begin
         nxt_sys.mem.addr = rise_ff.wr_addr;
         nxt_sys.mem.wdata = rise_ff.wr_data;
         nxt_sys.mem.we = sys_ff.armed;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         sys_ff <= sotp_pkg::SYS_RST;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   assign o_so = fall_ff.so;
   // pause floats the pin at once, not at the next clock edge
   assign o_so_oe = fall_ff.oe & i_hold_n & sys_ff.armed & ~i_cs_n;
   assign o_mode3 = sys_ff.mode3;
   assign o_mem_req = sys_ff.mem;

endmodule

`default_nettype wire

// File: include/sotp_pkg.sv
// shared constants, state encodings and carriers of the serial otp slave
// assumes a byte-wide array port on the system clock side
package sotp_pkg;
   localparam int ADDR_W = 16;
   localparam logic [7:0] STATUS_BYTE = 8'h8c;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_STAT = 8'h05;
   localparam logic [7:0] OP_IDENT = 8'h15;
   localparam logic [7:0] OP_PROG = 8'h99;
   localparam logic [7:0] OP_MASK_X = 8'hf7;
   localparam logic [7:0] OP_MASK_ALL = 8'hff;
   localparam logic [4:0] OPC_LAST = 5'h07;
   localparam logic [4:0] PAD_LAST = 5'h0f;
   localparam logic [4:0] ADDR_LAST = 5'h1f;
   localparam logic [2:0] BYTE_FIRST = 3'h0;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   localparam int SY_CS = 0;
   localparam int SY_SCK = 1;
   localparam int SY_RD = 2;
   localparam int SY_WR = 3;

   typedef enum logic [8:0] {
      ST_OPC = 9'h001,
      ST_RPAD = 9'h002,
      ST_RADDR = 9'h004,
      ST_RDATA = 9'h008,
      ST_STAT = 9'h010,
      ST_IDENT = 9'h020,
      ST_PADDR = 9'h040,
      ST_PDATA = 9'h080,
      ST_IGN = 9'h100
   } sotp_cmd_t;

   typedef struct packed {
      sotp_cmd_t cmd;
      logic [4:0] bitcnt;
      logic [7:0] sh;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] rd_addr;
      logic rd_tog;
      logic [ADDR_W-1:0] wr_addr;
      logic [7:0] wr_data;
      logic wr_tog;
      logic ident_dev;
   } sotp_rise_t;

   typedef struct packed {
      logic [7:0] byte_q;
      logic so;
      logic oe;
   } sotp_fall_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic we;
   } sotp_mem_req_t;

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic cs_f;
      logic sck_f;
      logic mode3;
      logic seen_high;
      logic armed;
      logic rd_pend;
      logic [7:0] rdata;
      sotp_mem_req_t mem;
   } sotp_sys_t;

   localparam sotp_rise_t RISE_RST = '{cmd: ST_OPC, default: '0};
   localparam sotp_fall_t FALL_RST = '0;
   // select counts as low until the synced pin shows it high, so a select held
   // low through reset gives no false falling edge; toggles match their sck side
   localparam sotp_sys_t SYS_RST = '{default: '0};
endpackage

// File: verification/sotp_slave_sva.sv
// assertions on the pins of the serial otp slave
// assumes binding to sotp_slave, all checks in the i_clk domain
`timescale 1ns/100ps
`default_nettype none
module sotp_slave_sva (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_hold_n,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic o_mode3,
   input wire sotp_pkg::sotp_mem_req_t o_mem_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence sel_hi;
      $fell(i_cs_n) && i_sck;
   endsequence
   sequence sel_lo;
      $fell(i_cs_n) && !i_sck;
   endsequence
   sequence held;
      !i_hold_n ##1 !i_hold_n;
   endsequence
   sequence we_up;
      $rose(o_mem_req.we);
   endsequence
   cs_float_a: assert property (i_cs_n |-> !o_so_oe) else $error("so on unselected");
   hold_float_a: assert property (!i_hold_n |-> !o_so_oe) else $error("so on in pause");
   hold_freeze_a: assert property (held |-> $stable(o_so)) else $error("so moved in pause");
   so_on_fall_a: assert property (
      !i_cs_n && $changed(o_so) |-> $fell(i_sck)) else $error("so moved off falling sck");
   oe_sck_low_a: assert property ($rose(o_so_oe) |-> !i_sck) else $error("so on at sck high");
   sel_quiet_a: assert property ($fell(i_cs_n) |-> !o_so_oe) else $error("so on at select");
   mode3_pick_a: assert property (
      sel_hi |-> ##[1:8] o_mode3) else $error("mode 3 not taken");
   mode0_pick_a: assert property (
      sel_lo |-> ##[1:8] !o_mode3) else $error("mode 0 not taken");
   we_pulse_a: assert property (we_up |=> !o_mem_req.we) else $error("write strobe too long");
endmodule
bind sotp_slave sotp_slave_sva u_sva (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sck(i_sck),
   .i_cs_n(i_cs_n), .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe(o_so_oe),
   .o_mode3(o_mode3), .o_mem_req(o_mem_req));
`default_nettype wire

// File: verification/sotp_host.sv
// spi host model on the serial side of the otp slave
// assumes a 4 ns i_clk; sck half period is ten clock cycles
`timescale 1ns/100ps
`default_nettype none
module sotp_host (
   input wire logic i_clk,
   input wire logic i_so,
   input wire logic i_so_oe,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   output logic o_hold_n
);
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   task automatic half();
      repeat (10) @(negedge i_clk);
   endtask
   // pause taken and released with sck low, sck and si wiggle meanwhile
   task automatic pause();
      repeat (3) @(negedge i_clk);
      o_hold_n = 1'b0;
      repeat (3) begin
         half();
         o_sck = 1'b1;
         o_si = ~o_si;
         half();
         o_sck = 1'b0;
      end
      half();
      o_hold_n = 1'b1;
   endtask
   // msb first, si set with sck low, so sampled at the rise
   task automatic frame(input logic m3, input int n, input int hold_at,
                        input logic [63:0] tx, output logic [63:0] rx);
      rx = {64{1'bz}};
      o_sck = m3;
      half();
      o_cs_n = 1'b0;
      half();
      for (int i = n - 1; i >= 0; i--) begin
         o_sck = 1'b0;
         o_si = tx[i];
         if (i == hold_at) begin
            pause();
         end
         half();
         o_sck = 1'b1;
         rx[i] = i_so_oe ? i_so : 1'bz;
         half();
      end
      o_sck = m3;
      half();
      o_cs_n = 1'b1; // select raised after the last wanted byte
      o_si = ~o_si;
      half();
   endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the serial otp slave with host and array models
// assumes sotp_pkg, sotp_slave and sotp_host are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [7:0] MK = 8'h3e; // arbitrary value
   localparam logic [7:0] DV = 8'hc1; // arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sck, cs_n, si, hold_n, so, so_oe, mode3;
   logic [7:0] rdata;
   sotp_pkg::sotp_mem_req_t req;
   logic [7:0] mem [65536];
   logic [63:0] rx;
   int err_total = 0;
   int comparisons = 0;
   always #2 clk = ~clk;
   sotp_slave #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) u_sotp_slave (.i_clk(clk),
      .i_reset_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
      .o_so(so), .o_so_oe(so_oe), .o_mode3(mode3), .o_mem_req(req), .i_mem_rdata(rdata));
   sotp_host u_host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
      .o_si(si), .o_hold_n(hold_n));
   // array answers in the same cycle, as the slave expects
   assign rdata = mem[req.addr];
   always @(posedge clk) begin
      if (req.we) begin
         mem[req.addr] <= req.wdata;
      end
   end
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ (a[15:8] << 1) ^ 8'h5c;
   endfunction
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic t_power();
      chk("oe after reset", 64'h0, {63'h0, so_oe});
      $display("test power done");
   endtask
   // mode 3, wrap at top, garbage on si, pause inside the data
   task automatic t_read();
      u_host.frame(1'b1, 56, 20, {8'h0b, 8'hfe, 16'hffff, 24'h5a5a5a}, rx);
      chk("read data", {pat(16'hffff), pat(16'h0), pat(16'h1)}, rx[23:0]);
      chk("read quiet", {32{1'bz}}, rx[55:24]);
      chk("mode3", 64'h1, {63'h0, mode3});
      $display("test read done");
   endtask
   task automatic t_stat();
      u_host.frame(1'b0, 32, -1, {8'h0d, 24'h0}, rx);
      chk("status", 24'h8c8c8c, rx[23:0]);
      chk("mode0", 64'h0, {63'h0, mode3});
      $display("test status done");
   endtask
   task automatic t_ident();
      u_host.frame(1'b0, 40, -1, {8'h1d, 32'h0}, rx);
      chk("ident", {MK, DV, MK, DV}, rx[31:0]);
      $display("test ident done");
   endtask
   // unknown opcode, then a read whose last pad bit is one
   task automatic t_bad();
      logic [39:0] cmd [2];
      cmd[0] = {8'h42, 32'h0};
      cmd[1] = {8'h03, 8'hff, 24'h0};
      for (int k = 0; k < 2; k++) begin
         u_host.frame(1'b0, 40, -1, {24'h0, cmd[k]}, rx);
         chk("refused", {40{1'bz}}, rx[39:0]);
      end
      $display("test refuse done");
   endtask
   // program over the top location, then read the bytes back
   task automatic t_prog();
      u_host.frame(1'b0, 56, -1, {8'h99, 24'h12fffe, 24'h112233}, rx);
      chk("prog", 24'h112233, {mem[16'hfffe], mem[16'hffff], mem[16'h0]});
      u_host.frame(1'b0, 56, -1, {8'h03, 8'h00, 16'hfffe, 24'h0}, rx);
      chk("readback", 24'h112233, rx[23:0]);
      $display("test program done");
   endtask
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = pat(16'(i));
      end
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (20) @(negedge clk);
      t_power();
      t_read();
      t_stat();
      t_ident();
      t_bad();
      t_prog();
      complete_run();
   end
   // runs need about 6800 cycles
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      complete_run();
   end
endmodule
`default_nettype wire
